//--- common/qfr_pkg.sv
// Shared constants and types for the serial flash read controller
package qfr_pkg;

  localparam int QFR_WLEN_W = 7;
  localparam int QFR_WCNT_W = 12;
  localparam int QFR_DIV_W = 12;
  localparam int QFR_DLY_W = 2;
  localparam int QFR_ADDR_W = 24;
  localparam int QFR_WORD_MAX = 128;
  localparam int QFR_HDR_W = 32;

  localparam logic [5:0] QFR_HDR_LEFT_INIT = 6'h1f;
  localparam logic [1:0] QFR_TAIL_PERIODS = 2'h2;

  typedef enum logic [1:0] {
    QFR_LN_1 = 2'h0,
    QFR_LN_2 = 2'h1,
    QFR_LN_4 = 2'h2
  } qfr_lines_t;

  typedef enum logic [1:0] {
    QFR_PIN_3 = 2'h0,
    QFR_PIN_4 = 2'h1,
    QFR_PIN_6 = 2'h2
  } qfr_pins_t;

  typedef enum logic [4:0] {
    QFR_IDLE = 5'h01,
    QFR_LEAD = 5'h02,
    QFR_XFER = 5'h04,
    QFR_TAIL = 5'h08,
    QFR_DONE = 5'h10
  } qfr_state_t;

endpackage

//--- hw/qfr_clk_div.sv
// Serial clock divider with period-end pulse and gated clock output
`timescale 1ns/1ps
module qfr_clk_div import qfr_pkg::*; #(
  parameter int DIV_W = QFR_DIV_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic gate_in,
  input wire logic [DIV_W-1:0] factor_in,
  output logic sclk_out,
  output logic fall_out
);

  logic [DIV_W:0] cnt;
  logic [DIV_W:0] next_cnt;
  logic sclk;
  logic next_sclk;
  logic [DIV_W:0] pm1;
  logic [DIV_W:0] hi_len;
  logic [DIV_W:0] lo_m1;

  // Factor zero still needs two phases, so it behaves like factor one
  assign pm1 = (factor_in == '0) ? (DIV_W+1)'(1) : {1'b0, factor_in};
  assign hi_len = (DIV_W+1)'((pm1 + (DIV_W+1)'(1)) >> 1);
  assign lo_m1 = pm1 - hi_len;
  assign fall_out = run_in && (cnt == pm1);
  assign sclk_out = sclk;

  always_comb begin
    next_cnt = cnt;
    next_sclk = sclk;
    if (!run_in) begin
      next_cnt = '0;
      next_sclk = 1'b0;
    end else if (cnt == pm1) begin
      next_cnt = '0;
      next_sclk = 1'b0;
    end else begin
      next_cnt = cnt + (DIV_W+1)'(1);
      if (cnt == lo_m1) begin
        next_sclk = gate_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      sclk <= 1'b0;
    end else begin
      cnt <= next_cnt;
      sclk <= next_sclk;
    end
  end

endmodule // qfr_clk_div

//--- hw/qfr_flash_reader.sv
// Controller-only serial flash read engine with 1/2/4 data lines
//
// Contract
// - Port is controller only; it makes clock and chip select itself.
// - Reads use one, two or four data lines.
// - A mapped read request starts the whole serial fetch by itself.
// - Word length programmable from 1 to 128 bits.
// - Words per frame programmable from 1 to 4096.
// - Three, four or six pin wiring picks the active data lines.
// - Optional interrupt on each word or on frame end, software picks.
// - Zero to three clock periods between select and first data.
// - Divider duty is half for zero or odd, (F/2)/(F+1) for even.
// - Clock mode zero: clock idles low, phase zero.
// - Read data is sampled on the serial clock falling edge.
// - Select goes active M periods before first falling edge, M=delay+1.
// - Select released two periods after the last falling edge.
// - First output bit placed one period before first falling edge.
`timescale 1ns/1ps
module qfr_flash_reader import qfr_pkg::*; #(
  parameter int WLEN_W = QFR_WLEN_W,
  parameter int WCNT_W = QFR_WCNT_W,
  parameter int DIV_W = QFR_DIV_W,
  parameter int ADDR_W = QFR_ADDR_W,
  parameter int WORD_MAX = QFR_WORD_MAX,
  parameter logic [7:0] OP_1 = 8'h03,
  parameter logic [7:0] OP_2 = 8'h3b,
  parameter logic [7:0] OP_4 = 8'h6b
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [DIV_W-1:0] clock_divide_factor_in,
  input wire logic [QFR_DLY_W-1:0] cs_to_data_delay_in,
  input wire logic [1:0] line_mode_in,
  input wire logic [1:0] pin_mode_in,
  input wire logic [WLEN_W-1:0] word_len_in,
  input wire logic [WCNT_W-1:0] word_count_in,
  input wire logic irq_enable_in,
  input wire logic irq_on_word_in,
  input wire logic mm_read_in,
  input wire logic [ADDR_W-1:0] mm_addr_in,
  input wire logic [3:0] data_in,
  output logic busy_out,
  output logic [WORD_MAX-1:0] word_data_out,
  output logic word_valid_out,
  output logic frame_done_out,
  output logic irq_out,
  output logic sclk_out,
  output logic cs_n_out,
  output logic data0_out,
  output logic data0_oe_n_out
);

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  qfr_state_t state, next_state;
  logic [DIV_W-1:0] fac, next_fac;
  logic [QFR_DLY_W-1:0] dd, next_dd;
  qfr_lines_t ln, next_ln;
  logic pin3, next_pin3;
  logic [WLEN_W-1:0] wlen, next_wlen;
  logic [WCNT_W-1:0] wcnt, next_wcnt;
  logic sel, next_sel;
  logic ien, next_ien;
  logic [QFR_HDR_W-1:0] hdr, next_hdr;
  logic [5:0] hdr_left, next_hdr_left;
  logic in_hdr, next_in_hdr;
  logic [1:0] per_left, next_per_left;
  logic [7:0] bit_left, next_bit_left;
  logic [WCNT_W-1:0] word_left, next_word_left;
  logic [WORD_MAX-1:0] sr, next_sr, sr_shift;
  logic [WORD_MAX-1:0] word_data, next_word_data;
  logic word_valid, next_word_valid;
  logic frame_done, next_frame_done;
  logic irq, next_irq;
  logic cs_n, next_cs_n;
  logic d0, next_d0;
  logic d0_oe_n, next_d0_oe_n;
  qfr_lines_t eff_ln;
  logic [7:0] opcode;
  logic [7:0] step;
  logic fall;
  logic run;

  // Wiring limits the usable lines: quad needs all six pins
  always_comb begin
    case (pin_mode_in)
      QFR_PIN_4: eff_ln = (line_mode_in inside {QFR_LN_2, QFR_LN_4}) ?
                          QFR_LN_2 : QFR_LN_1;
      QFR_PIN_6: eff_ln = (line_mode_in == QFR_LN_2) ? QFR_LN_2 :
                          (line_mode_in == QFR_LN_4) ? QFR_LN_4 : QFR_LN_1;
      default: eff_ln = QFR_LN_1;
    endcase
    case (eff_ln)
      QFR_LN_2: opcode = OP_2;
      QFR_LN_4: opcode = OP_4;
      default: opcode = OP_1;
    endcase
  end

  assign step = 8'h01 << ln;

  // Three-pin wiring reads back on the shared line
  always_comb begin
    case (ln)
      QFR_LN_1: sr_shift = {sr[WORD_MAX-2:0], pin3 ? data_in[0] : data_in[1]};
      QFR_LN_2: sr_shift = {sr[WORD_MAX-3:0], data_in[1:0]};
      default: sr_shift = {sr[WORD_MAX-5:0], data_in};
    endcase
  end

  assign run = (state == QFR_LEAD) || (state == QFR_XFER) ||
               (state == QFR_TAIL);

  qfr_clk_div #(.DIV_W(DIV_W)) u_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .run_in(run),
    .gate_in(state == QFR_XFER),
    .factor_in(fac),
    .sclk_out(sclk_out),
    .fall_out(fall)
  );

  always_comb begin
    next_state = state;
    next_fac = fac;
    next_dd = dd;
    next_ln = ln;
    next_pin3 = pin3;
    next_wlen = wlen;
    next_wcnt = wcnt;
    next_sel = sel;
    next_ien = ien;
    next_hdr = hdr;
    next_hdr_left = hdr_left;
    next_in_hdr = in_hdr;
    next_per_left = per_left;
    next_bit_left = bit_left;
    next_word_left = word_left;
    next_sr = sr;
    next_word_data = word_data;
    next_word_valid = 1'b0;
    next_frame_done = 1'b0;
    next_irq = 1'b0;
    next_cs_n = cs_n;
    next_d0 = d0;
    next_d0_oe_n = d0_oe_n;
    unique case (state)
      QFR_IDLE: begin
        if (mm_read_in) begin
          next_fac = clock_divide_factor_in;
          next_dd = cs_to_data_delay_in;
          next_ln = eff_ln;
          // Unused wiring code falls back to three-pin
          next_pin3 = !(pin_mode_in inside {QFR_PIN_4, QFR_PIN_6});
          next_wlen = word_len_in;
          next_wcnt = word_count_in;
          next_sel = irq_on_word_in;
          next_ien = irq_enable_in;
          next_hdr = {opcode, mm_addr_in};
          next_hdr_left = QFR_HDR_LEFT_INIT;
          next_in_hdr = 1'b1;
          next_word_left = word_count_in;
          next_bit_left = {1'b0, word_len_in} + 8'h01;
          next_sr = '0;
          next_cs_n = 1'b0;
          if (cs_to_data_delay_in == '0) begin
            next_state = QFR_XFER;
            next_d0 = opcode[7];
            next_d0_oe_n = 1'b0;
          end else begin
            next_state = QFR_LEAD;
            next_per_left = cs_to_data_delay_in;
          end
        end
      end
      QFR_LEAD: begin
        if (fall) begin
          if (per_left == 2'h1) begin
            next_state = QFR_XFER;
            next_d0 = hdr[QFR_HDR_W-1];
            next_d0_oe_n = 1'b0;
          end else begin
            next_per_left = per_left - 2'h1;
          end
        end
      end
      QFR_XFER: begin
        if (fall && in_hdr) begin
          if (hdr_left != '0) begin
            next_hdr = hdr << 1;
            next_d0 = hdr[QFR_HDR_W-2];
            next_hdr_left = hdr_left - 6'h01;
          end else begin
            // Let go of the shared line before the flash answers
            next_in_hdr = 1'b0;
            next_d0 = 1'b0;
            next_d0_oe_n = 1'b1;
          end
        end else if (fall) begin
          next_sr = sr_shift;
          if (bit_left <= step) begin
            next_word_data = sr_shift;
            next_word_valid = 1'b1;
            next_irq = ien && sel;
            next_sr = '0;
            next_bit_left = {1'b0, wlen} + 8'h01;
            if (word_left == '0) begin
              next_state = QFR_TAIL;
              next_per_left = QFR_TAIL_PERIODS;
            end else begin
              next_word_left = word_left - WCNT_W'(1);
            end
          end else begin
            next_bit_left = bit_left - step;
          end
        end
      end
      QFR_TAIL: begin
        if (fall) begin
          if (per_left == 2'h1) begin
            next_cs_n = 1'b1;
            next_state = QFR_DONE;
          end else begin
            next_per_left = per_left - 2'h1;
          end
        end
      end
      QFR_DONE: begin
        next_frame_done = 1'b1;
        next_irq = ien && !sel;
        next_state = QFR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= QFR_IDLE;
      fac <= '0;
      dd <= '0;
      ln <= QFR_LN_1;
      pin3 <= 1'b0;
      wlen <= '0;
      wcnt <= '0;
      sel <= 1'b0;
      ien <= 1'b0;
      hdr <= '0;
      hdr_left <= '0;
      in_hdr <= 1'b0;
      per_left <= '0;
      bit_left <= '0;
      word_left <= '0;
      sr <= '0;
      word_data <= '0;
      word_valid <= 1'b0;
      frame_done <= 1'b0;
      irq <= 1'b0;
      cs_n <= 1'b1;
      d0 <= 1'b0;
      d0_oe_n <= 1'b1;
    end else begin
      state <= next_state;
      fac <= next_fac;
      dd <= next_dd;
      ln <= next_ln;
      pin3 <= next_pin3;
      wlen <= next_wlen;
      wcnt <= next_wcnt;
      sel <= next_sel;
      ien <= next_ien;
      hdr <= next_hdr;
      hdr_left <= next_hdr_left;
      in_hdr <= next_in_hdr;
      per_left <= next_per_left;
      bit_left <= next_bit_left;
      word_left <= next_word_left;
      sr <= next_sr;
      word_data <= next_word_data;
      word_valid <= next_word_valid;
      frame_done <= next_frame_done;
      irq <= next_irq;
      cs_n <= next_cs_n;
      d0 <= next_d0;
      d0_oe_n <= next_d0_oe_n;
    end
  end

  assign busy_out = (state != QFR_IDLE);
  assign word_data_out = word_data;
  assign word_valid_out = word_valid;
  assign frame_done_out = frame_done;
  assign irq_out = irq;
  assign cs_n_out = cs_n;
  assign data0_out = d0;
  assign data0_oe_n_out = d0_oe_n;

  // Checking helpers: cycle counters around serial clock events
  logic [DIV_W+2:0] per_cyc, hi_len, lead_cnt, tail_cnt, hi_cnt, drv_cnt;
  logic [7:0] falls, exp_falls;
  logic [WCNT_W:0] words;
  logic first_seen, sclk_prev;

  assign per_cyc = (fac == '0) ? (DIV_W+3)'(2) : (DIV_W+3)'(fac) + 1'b1;
  assign hi_len = per_cyc >> 1;
  assign exp_falls = 8'(({1'b0, wlen} + step) >> ln);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lead_cnt <= '0;
      tail_cnt <= '0;
      hi_cnt <= '0;
      drv_cnt <= '0;
      falls <= '0;
      words <= '0;
      first_seen <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_out;
      lead_cnt <= (state == QFR_IDLE) ? '0 : lead_cnt + 1'b1;
      drv_cnt <= d0_oe_n ? '0 : drv_cnt + 1'b1;
      tail_cnt <= (sclk_prev && !sclk_out) ? (DIV_W+3)'(1) : tail_cnt + 1'b1;
      hi_cnt <= sclk_out ? hi_cnt + 1'b1 : '0;
      if (state == QFR_IDLE) begin
        first_seen <= 1'b0;
        words <= '0;
        falls <= '0;
      end else begin
        if (sclk_prev && !sclk_out) begin
          first_seen <= 1'b1;
        end
        if (fall && !in_hdr && state == QFR_XFER) begin
          falls <= falls + 8'h01;
        end
        if (word_valid) begin
          words <= words + 1'b1;
          falls <= (fall && !in_hdr && state == QFR_XFER) ? 8'h01 : 8'h00;
        end
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_cs_release;
    $rose(cs_n_out);
  endsequence
  sequence s_done_flag;
    frame_done_out && cs_n_out && !busy_out;
  endsequence

  AST_IDLE_QUIET: assert property (!busy_out |-> !sclk_out && cs_n_out)
    else $error("clock or select active between frames");
  AST_START: assert property (!busy_out && mm_read_in |=> !cs_n_out)
    else $error("mapped read did not start a frame");
  AST_LEAD: assert property ($fell(sclk_out) && !first_seen |->
      lead_cnt == per_cyc * ((DIV_W+3)'(dd) + 1'b1))
    else $error("select lead before first falling edge wrong");
  AST_FIRST_BIT: assert property ($fell(sclk_out) && !first_seen |->
      drv_cnt == per_cyc)
    else $error("first bit not one period before first fall");
  AST_TAIL: assert property ($rose(cs_n_out) |-> tail_cnt == 2 * per_cyc)
    else $error("select release not two periods after last fall");
  AST_DUTY: assert property ($fell(sclk_out) |-> $past(hi_cnt) + 1'b1 ==
      hi_len)
    else $error("serial clock high time wrong");
  AST_SAMPLE_EDGE: assert property (word_valid_out |-> $fell(sclk_out))
    else $error("word not completed on a falling edge");
  AST_WORD_LEN: assert property (word_valid_out |->
      $past(falls) + 1'b1 == exp_falls)
    else $error("word length in clock edges wrong");
  AST_FRAME_LEN: assert property (frame_done_out |->
      words == {1'b0, wcnt} + 1'b1)
    else $error("frame word count wrong");
  AST_DONE_ORDER: assert property (s_cs_release |-> ##1 s_done_flag)
    else $error("frame done not after select release");
  AST_IRQ_SRC: assert property (irq_out |->
      ien && (sel ? word_valid_out : frame_done_out))
    else $error("interrupt from wrong source");
  AST_LINE_FREE: assert property (state == QFR_XFER && !in_hdr |->
      data0_oe_n_out)
    else $error("shared line driven during read");
  AST_MODE0: assert property ($rose(sclk_out) |-> $stable(data0_out))
    else $error("data changed on rising edge");

endmodule // qfr_flash_reader

//--- verif/qfr_flash_model.sv
// Behavioural serial flash answering reads on one, two or four lines
`timescale 1ns/1ps
module qfr_flash_model (
  input wire logic clk_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic data0_in,
  input wire logic [2:0] lanes_in,
  input wire logic on_d0_in,
  input wire logic [127:0] pat_in,
  output logic [3:0] data_out,
  output logic [31:0] hdr_out
);
  logic [127:0] pat = 128'h0;
  int nr = 0;
  int nfl = 0;
  initial data_out = 4'h5;
  initial hdr_out = 32'h0;
  always @(negedge cs_n_in) begin
    nr = 0;
    nfl = 0;
    pat = pat_in;
  end
  // Header is taken on rising edges, mode zero
  always @(posedge sclk_in) begin
    if (!cs_n_in && nr < 32) begin
      hdr_out <= {hdr_out[30:0], data0_in};
      nr = nr + 1;
    end
  end
  // Launch right after the fall; the reader sampled the old bits
  always @(negedge sclk_in) begin
    nfl = nfl + 1;
    if (nfl >= 32 && !cs_n_in) begin
      case (lanes_in)
        3'h4: data_out <= pat[127:124];
        3'h2: data_out <= {~pat[127:126], pat[127:126]};
        default: data_out <= on_d0_in ? {{3{~pat[127]}}, pat[127]} :
          {~pat[127], ~pat[127], pat[127], ~pat[127]};
      endcase
      pat = 128'({pat, pat} >> (128 - lanes_in));
    end
  end
  // Deselected lines never keep the last bit
  always @(posedge clk_in) begin
    if (cs_n_in) data_out <= ~data_out;
  end
endmodule // qfr_flash_model

//--- verif/quad_serial_flash_read_master_tb.sv
// Self-checking bench for the serial flash read controller
`timescale 1ns/1ps
module quad_serial_flash_read_master_tb;
  localparam logic [127:0] PAT = 128'hc3a5_0f96_e11d_5b72_8844_f00d_3c69_a1b7;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] factor = 12'h1;
  logic [1:0] dly = 2'h0;
  logic [1:0] lmode = 2'h0;
  logic [1:0] pmode = 2'h0;
  logic [6:0] wlen = 7'h0;
  logic [11:0] wcnt = 12'h0;
  logic irq_en = 1'b0;
  logic irq_word = 1'b0;
  logic mm_read = 1'b0;
  logic [23:0] mm_addr = 24'h0;
  logic [2:0] lanes = 3'h1;
  logic on_d0 = 1'b1;
  logic [3:0] dline;
  logic [3:0] fd;
  logic [31:0] hdr;
  logic busy, wvalid, fdone, irq, sclk, cs_n, d0, d0_oe_n;
  logic [127:0] wdata;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0, per = 2, ie_v = 0, iw_v = 0, ncs = 0, nf = 0, hi = 0;
  int t_cs, t_oe, t_f1, t_lf, t_csr, t_done;
  logic ps = 1'b0;
  logic pc = 1'b1;

  always #12.5 clk = ~clk;
  assign dline = {fd[3:1], d0_oe_n ? fd[0] : d0};

  qfr_flash_reader i_qfr_flash_reader (.clk_in(clk), .nrst_in(nrst),
    .clock_divide_factor_in(factor), .cs_to_data_delay_in(dly),
    .line_mode_in(lmode), .pin_mode_in(pmode), .word_len_in(wlen),
    .word_count_in(wcnt), .irq_enable_in(irq_en), .irq_on_word_in(irq_word),
    .mm_read_in(mm_read), .mm_addr_in(mm_addr), .data_in(dline),
    .busy_out(busy), .word_data_out(wdata), .word_valid_out(wvalid),
    .frame_done_out(fdone), .irq_out(irq), .sclk_out(sclk), .cs_n_out(cs_n),
    .data0_out(d0), .data0_oe_n_out(d0_oe_n));

  qfr_flash_model i_qfr_flash_model (.clk_in(clk), .sclk_in(sclk),
    .cs_n_in(cs_n), .data0_in(d0), .lanes_in(lanes), .on_d0_in(on_d0),
    .pat_in(PAT), .data_out(fd), .hdr_out(hdr));

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("Mismatches %0d, comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Edge timing seen from the module clock
  always @(posedge clk) begin
    cyc++;
    if (pc && !cs_n) begin
      t_cs = cyc;
      t_oe = -1;
      nf = 0;
      ncs++;
    end
    if (!cs_n && !d0_oe_n && t_oe < 0) t_oe = cyc;
    if (sclk) hi++;
    if (ps && !sclk) begin
      nf++;
      if (nf == 1) t_f1 = cyc;
      else chk(cyc - t_lf, per);
      chk(hi, per / 2);
      hi = 0;
      t_lf = cyc;
    end
    if (!pc && cs_n) t_csr = cyc;
    if (fdone) t_done = cyc;
    if (cs_n) chk(sclk, 1'b0);
    if (wvalid | fdone | irq) chk(irq, ie_v && (iw_v ? wvalid : fdone));
    ps = sclk;
    pc = cs_n;
  end

  task automatic xfer(input int f, dd, lm, pm, wl, wc, ie, iw, pk);
    int g, t, to, n0;
    logic [23:0] ad;
    logic [127:0] r;
    g = (pm == 0 || pm == 3 || lm == 0 || lm == 3) ? 1 :
      (lm == 1 || pm == 1) ? 2 : 4;
    t = ((wl + g - 1) / g) * g;
    per = (f == 0) ? 2 : f + 1;
    ie_v = ie;
    iw_v = iw;
    ad = 24'ha5c3f0 ^ 24'(ncs * 24'h1111);
    n0 = ncs;
    @(posedge clk);
    lanes <= 3'(g);
    on_d0 <= (pm == 0 || pm == 3);
    factor <= 12'(f);
    dly <= 2'(dd);
    lmode <= 2'(lm);
    pmode <= 2'(pm);
    wlen <= 7'(wl - 1);
    wcnt <= 12'(wc);
    irq_en <= 1'(ie);
    irq_word <= 1'(iw);
    mm_addr <= ad;
    mm_read <= 1'b1;
    @(posedge clk);
    mm_read <= 1'b0;
    if (pk) begin
      repeat (20) @(posedge clk);
      mm_read <= 1'b1;
      lmode <= 2'h2;
      @(posedge clk);
      mm_read <= 1'b0;
    end
    for (int k = 0; k <= wc; k++) begin
      to = 0;
      do begin
        @(posedge clk);
        to++;
      end while (wvalid !== 1'b1 && to < 4000);
      chk(to < 4000, 1'b1);
      r = 128'({PAT, PAT} >> (128 - ((k * t) % 128)));
      chk(wdata, r >> (128 - t));
    end
    to = 0;
    do begin
      @(posedge clk);
      to++;
    end while (fdone !== 1'b1 && to < 4000);
    chk(to < 4000, 1'b1);
    // Let the edge monitor finish its bookkeeping first
    @(negedge clk);
    chk(busy, 1'b0);
    chk(hdr, {(g == 4) ? 8'h6b : (g == 2) ? 8'h3b : 8'h03, ad});
    chk(ncs - n0, 1);
    chk(nf, 32 + (wc + 1) * (t / g));
    chk(t_f1 - t_cs, (dd + 1) * per);
    chk(t_oe - t_cs, dd * per);
    chk(t_csr - t_lf, 2 * per);
    chk(t_done - t_csr, 1);
  endtask

  task automatic t_modes();
    int lm[9] = '{0, 0, 1, 2, 2, 3, 1, 2, 3};
    int pm[9] = '{0, 1, 2, 2, 1, 2, 0, 3, 1};
    for (int i = 0; i < 9; i++) begin
      xfer(1, 0, lm[i], pm[i], 8, 1, 1, 1, 0);
    end
  endtask

  task automatic t_delays();
    for (int d = 0; d < 4; d++) begin
      xfer(5, d, 2, 2, 16, 0, 1, 0, 0);
    end
  endtask

  task automatic t_divs();
    int fs[4] = '{0, 2, 4, 3};
    for (int i = 0; i < 4; i++) begin
      xfer(fs[i], 1, 1, 2, 12, 2, 0, 1, 0);
    end
  endtask

  task automatic t_lengths();
    xfer(1, 2, 0, 1, 1, 0, 1, 0, 0);
    xfer(1, 0, 2, 2, 128, 1, 1, 1, 0);
    xfer(2, 3, 2, 2, 7, 2, 1, 0, 0);
  endtask

  task automatic t_count();
    xfer(0, 0, 2, 2, 1, 4095, 1, 0, 0);
  endtask

  task automatic t_refuse();
    xfer(1, 1, 0, 0, 16, 3, 1, 0, 1);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk(cs_n, 1'b1);
    t_modes();
    t_delays();
    t_divs();
    t_lengths();
    t_count();
    t_refuse();
    results();
  end

  // Whole run is near 11.5k cycles
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    results();
  end
endmodule // quad_serial_flash_read_master_tb
